// file: hdl/rws_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Far side stretches cycle via ready
// - Ready polarity is selectable
// - Synchronous mode samples ready directly
// - Asynchronous mode adds a two-stage synchroniser
// - Async ready held one period plus setup
// - Ready may drop at strobe rise
// - Ready removed before next sample point
// - Inactive ready inserts one wait state
// - Active ready ends the access phase
// - Async sample point lies later
// - Ready evaluated after programmed access waits
// - Read data latched at strobe rise edge
// - Far side may drop data after strobe
// - Five phases, each programmable
// - Ready governs access phase length only
module rws_ctrl #(
    parameter int AW = 16,
    parameter int DW = 16
) (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST,
    // Bus side
    rws_if.ctrl BUS,
    // Configuration
    input wire logic [rws_pkg::CFG_W-1:0] TIMING_CFG,
    input wire logic READY_ACT_HIGH,
    input wire logic READY_ASYNC,
    input wire logic READY_EN,
    // Request
    input wire logic REQ_VALID,
    input wire logic REQ_WRITE,
    input wire logic [AW-1:0] REQ_ADDR,
    input wire logic [DW-1:0] REQ_WDATA,
    output logic REQ_READY,
    // Answer
    output logic DONE,
    output logic [DW-1:0] RD_DATA,
    output logic REF_CLK_OUT
);
    initial begin
        if (AW < 1 || DW < 1) $error("Bad widths");
    end

    rws_pkg::rws_phase_t ph_r, ph_nxt;
    logic [5:0] cnt_r, cnt_nxt;
    logic wr_r;
    logic sync1_r;
    logic sync2_r;
    logic async_r;
    logic [AW-1:0] addr_r;
    logic [DW-1:0] wdata_r;
    logic rd_n_r;
    logic wr_n_r;
    logic oe_r;
    logic [rws_pkg::CFG_W-1:0] cfg_r;

    wire [2:0] len_ab = TIMING_CFG[rws_pkg::AB_LSB +: 3];
    wire [1:0] len_c = cfg_r[rws_pkg::C_LSB +: 2];
    wire len_d = cfg_r[rws_pkg::D_LSB];
    wire [4:0] len_e = cfg_r[rws_pkg::E_LSB +: 5];
    wire [1:0] len_f = cfg_r[rws_pkg::F_LSB +: 2];
    // Zero length command delay or data setup phases are skipped
    wire c_skip = len_c == 2'd0;
    wire d_skip = !len_d;
    // Loaded counts: C lasts len_c periods, access lasts len_e + 1
    wire [5:0] cnt_c = {4'd0, len_c} - 6'd1;
    wire [5:0] cnt_e = {1'b0, len_e};
    wire rdy_raw = READY_ACT_HIGH ? BUS.ready : !BUS.ready;
    wire rdy_seen = async_r ? sync2_r : rdy_raw;
    wire cnt_done = cnt_r == 6'd0;
    wire start = ph_r == rws_pkg::PH_IDLE && REQ_VALID;

    always_comb begin
        ph_nxt = ph_r;
        cnt_nxt = cnt_done ? 6'd0 : cnt_r - 6'd1;
        case (ph_r)
            rws_pkg::PH_IDLE: if (start) begin
                ph_nxt = rws_pkg::PH_AB;
                cnt_nxt = (len_ab == 3'd0) ? 6'd0 : {3'd0, len_ab} - 6'd1;
            end
            rws_pkg::PH_AB: if (cnt_done) begin
                if (!c_skip) begin
                    ph_nxt = rws_pkg::PH_C;
                    cnt_nxt = cnt_c;
                end else if (!d_skip) begin
                    ph_nxt = rws_pkg::PH_D;
                    cnt_nxt = 6'd0;
                end else begin
                    ph_nxt = rws_pkg::PH_E;
                    cnt_nxt = cnt_e;
                end
            end
            rws_pkg::PH_C: if (cnt_done) begin
                if (!d_skip) begin
                    ph_nxt = rws_pkg::PH_D;
                    cnt_nxt = 6'd0;
                end else begin
                    ph_nxt = rws_pkg::PH_E;
                    cnt_nxt = cnt_e;
                end
            end
            rws_pkg::PH_D: if (cnt_done) begin
                ph_nxt = rws_pkg::PH_E;
                // Field value n gives n+1 periods
                cnt_nxt = cnt_e;
            end
            rws_pkg::PH_E: if (cnt_done) begin
                // Ready looked at after programmed waits
                if (READY_EN) begin
                    ph_nxt = rws_pkg::PH_RDY;
                    cnt_nxt = async_r ? 6'(rws_pkg::ASYNC_EXTRA) : 6'd0;
                end else begin
                    ph_nxt = rws_pkg::PH_F;
                    cnt_nxt = {4'd0, len_f};
                end
            end
            rws_pkg::PH_RDY: begin
                if (cnt_done && rdy_seen) begin
                    ph_nxt = rws_pkg::PH_F;
                    cnt_nxt = {4'd0, len_f};
                end
            end
            rws_pkg::PH_F: if (cnt_done) begin
                ph_nxt = rws_pkg::PH_IDLE;
            end
            default: ph_nxt = rws_pkg::PH_IDLE;
        endcase
    end

    wire leave_access = ph_nxt == rws_pkg::PH_F && ph_r != rws_pkg::PH_F;
    wire cmd_on = ph_nxt == rws_pkg::PH_E && ph_r != rws_pkg::PH_E;

    assign BUS.addr = addr_r;
    assign BUS.rd_n = rd_n_r;
    assign BUS.wr_n = wr_n_r;
    assign BUS.wdata = wdata_r;
    assign BUS.wdata_oe = oe_r;

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            ph_r <= rws_pkg::PH_IDLE;
            cnt_r <= 6'd0;
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            async_r <= 1'b0;
            cfg_r <= rws_pkg::CFG_RESET;
            wr_r <= 1'b0;
            addr_r <= '0;
            wdata_r <= '0;
            rd_n_r <= 1'b1;
            wr_n_r <= 1'b1;
            oe_r <= 1'b0;
            REQ_READY <= 1'b0;
            DONE <= 1'b0;
            RD_DATA <= '0;
            REF_CLK_OUT <= 1'b0;
        end else begin
            ph_r <= ph_nxt;
            cnt_r <= cnt_nxt;
            sync1_r <= rdy_raw;
            sync2_r <= sync1_r;
            REF_CLK_OUT <= !REF_CLK_OUT;
            REQ_READY <= ph_nxt == rws_pkg::PH_IDLE;
            DONE <= 1'b0;
            if (start) begin
                cfg_r <= TIMING_CFG;
                async_r <= READY_ASYNC;
                wr_r <= REQ_WRITE;
                addr_r <= REQ_ADDR;
                wdata_r <= REQ_WDATA;
                oe_r <= REQ_WRITE;
            end
            if (cmd_on) begin
                rd_n_r <= wr_r;
                wr_n_r <= !wr_r;
            end
            // Capture read data with strobe rise
            if (leave_access) begin
                rd_n_r <= 1'b1;
                wr_n_r <= 1'b1;
                if (!wr_r) begin
                    RD_DATA <= BUS.data_bus;
                end
            end
            if (ph_r == rws_pkg::PH_F && cnt_done) begin
                oe_r <= 1'b0;
                DONE <= 1'b1;
            end
        end
    end
endmodule

// file: hdl/rws_ext.sv
`timescale 1ns/1ps
module rws_ext #(
    parameter int AW = 16,
    parameter int DW = 16
) (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST,
    // Bus side
    rws_if.ext BUS,
    // User side
    input wire logic READY_ACT_HIGH,
    input wire logic [7:0] DELAY,
    input wire logic [DW-1:0] RD_DATA,
    output logic [AW-1:0] WR_ADDR,
    output logic [DW-1:0] WR_DATA,
    output logic WR_STB
);
    logic [7:0] cnt_r;
    logic busy_r;
    logic rdy_r;
    logic rd_d_r;
    logic wr_d_r;
    logic [DW-1:0] rdata_r;
    logic oe_r;
    wire cmd = !BUS.rd_n || !BUS.wr_n;
    wire cmd_rise = (!BUS.rd_n && rd_d_r) || (!BUS.wr_n && wr_d_r);
    wire cmd_end = (BUS.rd_n && !rd_d_r) || (BUS.wr_n && !wr_d_r);
    wire rdy_nxt = cmd_end ? 1'b0 : (busy_r && cnt_r == 8'h00) ? 1'b1 : rdy_r;
    assign BUS.ready = READY_ACT_HIGH ? rdy_r : !rdy_r;
    assign BUS.rdata = rdata_r;
    assign BUS.rdata_oe = oe_r;

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            cnt_r <= 8'h00;
            busy_r <= 1'b0;
            rdy_r <= 1'b0;
            rd_d_r <= 1'b1;
            wr_d_r <= 1'b1;
            rdata_r <= '0;
            oe_r <= 1'b0;
            WR_ADDR <= '0;
            WR_DATA <= '0;
            WR_STB <= 1'b0;
        end else begin
            rd_d_r <= BUS.rd_n;
            wr_d_r <= BUS.wr_n;
            rdy_r <= rdy_nxt;
            WR_STB <= 1'b0;
            if (cmd_rise) begin
                busy_r <= 1'b1;
                cnt_r <= DELAY;
            end else if (busy_r && cnt_r != 8'h00) begin
                cnt_r <= cnt_r - 8'h01;
            end else if (busy_r) begin
                busy_r <= 1'b0;
            end
            if (cmd_end) begin
                busy_r <= 1'b0;
            end
            oe_r <= !BUS.rd_n;
            rdata_r <= RD_DATA;
            if (BUS.wr_n && !wr_d_r) begin
                WR_ADDR <= BUS.addr;
                WR_DATA <= BUS.data_bus;
                WR_STB <= 1'b1;
            end
        end
    end
    // Ready inactive again before next sample
    wire unused_ok = cmd;
endmodule

// file: hdl/rws_if.sv
`timescale 1ns/1ps
interface rws_if #(parameter int AW = 16, parameter int DW = 16);
    logic [AW-1:0] addr;
    logic rd_n;
    logic wr_n;
    logic [DW-1:0] wdata;
    logic wdata_oe;
    logic [DW-1:0] rdata;
    logic rdata_oe;
    logic ready;
    logic [DW-1:0] data_bus;
    assign data_bus = wdata_oe ? wdata : (rdata_oe ? rdata : '0);
    modport ctrl (output addr, rd_n, wr_n, wdata, wdata_oe, input data_bus, ready);
    modport ext (input addr, rd_n, wr_n, data_bus, output rdata, rdata_oe, ready);
endinterface

// file: hdl/rws_pkg.sv
package rws_pkg;
    // Phase duration limits in SYS_CLK periods
    localparam int AB_MIN = 1;
    localparam int AB_MAX = 5;
    localparam int C_MAX = 3;
    localparam int D_MAX = 1;
    localparam int E_MIN = 1;
    localparam int E_MAX = 32;
    localparam int F_MAX = 3;
    // Timing config field positions
    localparam int AB_LSB = 0;
    localparam int C_LSB = 3;
    localparam int D_LSB = 5;
    localparam int E_LSB = 6;
    localparam int F_LSB = 11;
    localparam int CFG_W = 13;
    localparam logic [12:0] CFG_RESET = 13'h0000;
    // Extra sample delay of the asynchronous ready path
    localparam int ASYNC_EXTRA = 1;

    typedef enum logic [2:0] {
        PH_IDLE, PH_AB, PH_C, PH_D, PH_E, PH_RDY, PH_F
    } rws_phase_t;
endpackage

// file: sim/rws_chk.sv
`timescale 1ns/1ps
module rws_chk #(parameter int AW = 16, parameter int DW = 16) (
    // Clock, reset and setup
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ready_act_high,
    input wire logic ready_en,
    // Bus
    input wire logic [AW-1:0] addr,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [DW-1:0] wdata,
    input wire logic wdata_oe,
    input wire logic rdata_oe,
    input wire logic ready
);
    wire logic rdy_act = (ready == ready_act_high);
    wire logic stb_rise_ok;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    assign stb_rise_ok = ready_en;
    strobe_excl_a: assert property (rd_n || wr_n)
        else $error("both strobes low");
    rst_idle_a: assert property (disable iff (1'b0) rst |-> rd_n && wr_n)
        else $error("strobe low in reset");
    rd_addr_hold_a: assert property (!rd_n && $past(!rd_n) |-> $stable(addr))
        else $error("address moved under read strobe");
    wr_data_hold_a: assert property (!wr_n && $past(!wr_n) |-> $stable(wdata))
        else $error("write data moved under strobe");
    bus_clash_a: assert property (!(wdata_oe && rdata_oe))
        else $error("both ends drive data");
    ready_gate_a: assert property (stb_rise_ok && ($rose(rd_n) || $rose(wr_n)) |->
        $past(rdy_act) || $past(rdy_act, 2) || $past(rdy_act, 3) || $past(rdy_act, 4))
        else $error("cycle ended without ready");
    rd_release_a: assert property (rdata_oe |-> !rd_n || $past(!rd_n) || $past(!rd_n, 2))
        else $error("read data driven outside read");
    access_min_a: assert property ($fell(rd_n) |=> !rd_n)
        else $error("read strobe too short");
    cover property ($rose(rd_n));
    cover property ($rose(wr_n));
    cover property (!rd_n && !rdy_act);
endmodule

// file: sim/tb_ready_wait_state_control.sv
`timescale 1ns/1ps
module tb_ready_wait_state_control;
    typedef struct {logic [3:0] m; logic [12:0] cfg; logic [7:0] dly;
        logic [15:0] a; logic [15:0] d;} rws_row_t;
    // Mode bits: write, async, ready enable, active high
    rws_row_t rows[8] = '{'{4'h3, 13'h0041, 8'h08, 16'h1234, 16'hA5A5},
        '{4'h7, 13'h0041, 8'h08, 16'h1235, 16'h5A5A}, '{4'h3, 13'h0041, 8'h14, 16'h1236, 16'h0F0F},
        '{4'hA, 13'h0041, 8'h04, 16'h2222, 16'h1357}, '{4'hF, 13'h0001, 8'h00, 16'h3333, 16'h2468},
        '{4'h1, 13'h1FFD, 8'h3C, 16'h4444, 16'hC3C3}, '{4'h8, 13'h0001, 8'h3C, 16'h0000, 16'hFFFF},
        '{4'h6, 13'h0741, 8'h00, 16'h5555, 16'h9999}};
    rws_row_t cur = '{4'h3, 13'h0041, 8'h00, 16'h0000, 16'h0000};
    logic sys_clk = 0, rst = 0, req_valid = 0, req_ready, done, wr_stb;
    logic [15:0] rd_data, wr_addr, wr_data;
    int n_errors = 0, checked = 0, lats[8];
    rws_if bus();
    rws_ctrl rws_ctrl_i (.SYS_CLK(sys_clk), .RST(rst), .BUS(bus), .TIMING_CFG(cur.cfg),
        .READY_ACT_HIGH(cur.m[0]), .READY_ASYNC(cur.m[2]), .READY_EN(cur.m[1]),
        .REQ_VALID(req_valid), .REQ_WRITE(cur.m[3]), .REQ_ADDR(cur.a), .REQ_WDATA(cur.d),
        .REQ_READY(req_ready), .DONE(done), .RD_DATA(rd_data), .REF_CLK_OUT());
    rws_ext rws_ext_i (.SYS_CLK(sys_clk), .RST(rst), .BUS(bus), .READY_ACT_HIGH(cur.m[0]),
        .DELAY(cur.dly), .RD_DATA(cur.d), .WR_ADDR(wr_addr), .WR_DATA(wr_data), .WR_STB(wr_stb));
    rws_chk rws_chk_i (.sys_clk(sys_clk), .rst(rst), .ready_act_high(cur.m[0]),
        .ready_en(cur.m[1]), .addr(bus.addr), .rd_n(bus.rd_n), .wr_n(bus.wr_n),
        .wdata(bus.wdata), .wdata_oe(bus.wdata_oe), .rdata_oe(bus.rdata_oe), .ready(bus.ready));
    always #2.5 sys_clk = ~sys_clk;
    task automatic wrap_up();
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Cycles from take to done when ready plays no part
    function automatic int base(input logic [12:0] c);
        return int'(c[2:0]) + int'(c[4:3]) + int'(c[5]) + int'(c[10:6]) + int'(c[12:11]) + 2;
    endfunction
    task automatic run(input rws_row_t r, output int lat);
        int k;
        k = 0;
        while (req_ready !== 1'b1 && k < 200) begin
            @(posedge sys_clk);
            #1 k++;
        end
        cur = r;
        req_valid = 1;
        @(posedge sys_clk);
        #1 req_valid = 0;
        lat = 0;
        while (done !== 1'b1 && lat < 2000) begin
            @(posedge sys_clk);
            #1 lat++;
        end
        if (k >= 200 || lat >= 2000) begin
            n_errors++;
            wrap_up();
        end
    endtask
    initial begin
        rst = 1;
        repeat (10) @(posedge sys_clk);
        #1 chk(16'({bus.rd_n, bus.wr_n, req_ready, done}), 16'h000C);
        rst = 0;
        @(posedge sys_clk);
        #1 chk(16'(req_ready), 16'h0001);
        foreach (rows[i]) begin
            run(rows[i], lats[i]);
            if (rows[i].m[3]) begin
                chk(wr_addr, rows[i].a);
                chk(wr_data, rows[i].d);
                chk(16'(wr_stb), 16'h0001);
            end else chk(rd_data, rows[i].d);
            if (rows[i].m[1]) chk(16'(lats[i] >= base(rows[i].cfg)), 16'h0001);
            else chk(16'(lats[i]), 16'(base(rows[i].cfg)));
        end
        chk(16'(lats[1] > lats[0]), 16'h0001);
        chk(16'(lats[2] > lats[0]), 16'h0001);
        // Reset during the address phase of a long cycle, before any strobe
        cur = rows[5];
        req_valid = 1;
        repeat (4) @(posedge sys_clk);
        #1 rst = 1;
        req_valid = 0;
        #1 chk(16'({bus.rd_n, bus.wr_n, req_ready, done}), 16'h000C);
        repeat (2) @(posedge sys_clk);
        #1 rst = 0;
        @(posedge sys_clk);
        #1 chk(16'(req_ready), 16'h0001);
        run(rows[0], lats[0]);
        chk(rd_data, rows[0].d);
        wrap_up();
    end
endmodule
